// ===== pkg/lrc_defs.svh
// Register offsets, field positions, reset values and counts of the ladder reference control.
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH
`define LRC_ADDR_W          4
`define LRC_OFF_CTRL0       4'h0
`define LRC_OFF_CTRL1       4'h1
`define LRC_OFF_STATUS      4'h2
`define LRC_BIT_EN          7
`define LRC_BIT_OE1         5
`define LRC_BIT_OE2         4
`define LRC_BIT_PSS         2
`define LRC_CODE_MSB        4
`define LRC_CODE_W          5
`define LRC_LEVELS          32
`define LRC_CTRL0_WMASK     8'hb4
`define LRC_CTRL1_WMASK     8'h1f
`define LRC_CTRL0_RST       8'h00
`define LRC_CTRL1_RST       8'h00
`define LRC_PINS            2
`endif

// ===== pkg/lrc_pkg.sv
// Types shared by the ladder reference control modules.
package lrc_pkg;
    typedef logic [7:0]  lrc_byte_t;
    typedef logic [4:0]  lrc_code_t;
    typedef logic [31:0] lrc_tap_t;
    typedef enum logic [1:0] {
        LRC_SRC_SUPPLY = 2'b01,
        LRC_SRC_EXTREF = 2'b10
    } lrc_src_e;
endpackage

// ===== pkg/lrc_ctl_if.sv
// Interface carrying decoded control settings from the register file to the ladder driver.
`timescale 1ns/100ps
interface lrc_ctl_if;
    import lrc_pkg::*;
    logic      conv_enable;
    logic      pos_source_select;
    logic      pin1_out_enable;
    logic      pin2_out_enable;
    lrc_code_t level_code;
    modport src (output conv_enable, output pos_source_select, output pin1_out_enable,
                 output pin2_out_enable, output level_code);
    modport dst (input conv_enable, input pos_source_select, input pin1_out_enable,
                 input pin2_out_enable, input level_code);
endinterface

// ===== hdl/lrc_ladder_drv.sv
// Ladder tap, source and pin override driver of the ladder reference control.
`timescale 1ns/100ps
`include "lrc_defs.svh"
module lrc_ladder_drv
    import lrc_pkg::*;
(
    input  wire logic     i_clk_sys,    // System clock.
    input  wire logic     i_nrst,       // Asynchronous reset, active low.
    lrc_ctl_if.dst        ctl,          // Control settings.
    output lrc_tap_t      o_tap_sel,    // One-hot ladder tap select.
    output lrc_src_e      o_src_sel,    // Upper source select.
    output logic          o_ladder_on,  // Ladder powered.
    output logic [1:0]    o_pin_ovr     // Pin override per pin.
);
    logic [1:0] pin_en;
    assign pin_en = {ctl.pin2_out_enable, ctl.pin1_out_enable};

    // Tap decoder registers a one-hot select; all taps open while off.
    genvar g;
    generate
        for (g = 0; g < `LRC_LEVELS; g++) begin : g_tap
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_tap_sel[g] <= 1'b0;
                end else begin
                    o_tap_sel[g] <= ctl.conv_enable && (ctl.level_code == lrc_code_t'(g));
                end
            end
        end
    endgenerate

    // Enable and source select follow the register one cycle later.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ladder_on <= 1'b0;
            o_src_sel   <= LRC_SRC_SUPPLY;
        end else begin
            o_ladder_on <= ctl.conv_enable;
            o_src_sel   <= ctl.pos_source_select ? LRC_SRC_EXTREF : LRC_SRC_SUPPLY;
        end
    end

    // Pin overrides connect the level and take the pin from digital use.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_ovr <= 2'b00;
        end else begin
            o_pin_ovr <= pin_en;
        end
    end
endmodule

// ===== hdl/lrc_top.sv
// Top of the ladder reference control: register file, pin gating and ladder driver.
//
// Overview of operation
// - The converter runs while the enable bit, bit 7 of control register 0, is one.
// - Bits 4 to 0 of control register 1 pick one of thirty-two ladder levels.
// - Bit 5 of control register 0 connects the level to the first output pin.
// - Bit 4 of control register 0 connects the level to the second output pin.
// - A pin carrying the level has its driver, pull-up and input detector disabled.
// - Reading a pin that carries the level returns zero.
// - Bit 2 of control register 0 chooses the upper source of the ladder.
// - The lower end of the ladder is always tied to ground.
// - Waking from sleep leaves control register 0 unchanged.
// - Any device reset clears every control bit and the level code.
// - Unimplemented bits of both registers read as zero.
// - The level is offered to the comparator positive input and an ADC channel.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "lrc_defs.svh"
module lrc_top
    import lrc_pkg::*;
(
    input  wire logic                    i_clk_sys,      // System clock, 125 MHz.
    input  wire logic                    i_nrst,         // Asynchronous device reset, active low.
    input  wire logic [`LRC_ADDR_W-1:0]  i_addr,         // Register address.
    input  wire logic [7:0]              i_wdata,        // Write data.
    input  wire logic                    i_wr,           // Write strobe.
    input  wire logic                    i_rd,           // Read strobe.
    output lrc_byte_t                    o_rdata,        // Read data, one cycle after strobe.
    input  wire logic                    i_sleep_wake,   // Wake-up event, no register effect.
    input  wire logic [1:0]              i_pin_in,       // Raw digital input of the two pins.
    output logic [1:0]                   o_pin_rd,       // Port read value of the two pins.
    output logic [1:0]                   o_pin_drv_off,  // Digital output driver disabled.
    output logic [1:0]                   o_pin_pullup_off, // Weak pull-up disabled.
    output logic [1:0]                   o_pin_inbuf_off,  // Input threshold detector disabled.
    output lrc_tap_t                     o_tap_sel,      // One-hot ladder tap select.
    output lrc_src_e                     o_upper_source, // Upper source select.
    output logic                         o_lower_source_gnd, // Lower end tied to ground.
    output logic                         o_ladder_on,    // Ladder powered.
    output logic                         o_ref_out_pin1, // Level switched to first pin.
    output logic                         o_ref_out_pin2, // Level switched to second pin.
    output logic                         o_level_to_cmp, // Level offered to comparator input.
    output logic                         o_level_to_adc  // Level offered to ADC channel.
);
    lrc_byte_t   ctrl0;
    lrc_byte_t   ctrl1;
    logic [1:0]  pin_ovr;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    lrc_ctl_if   ctl ();

    // Control registers; only device reset clears them, wake leaves them alone.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl0 <= `LRC_CTRL0_RST;
            ctrl1 <= `LRC_CTRL1_RST;
        end else if (i_wr) begin
            if (i_addr == `LRC_OFF_CTRL0) begin
                ctrl0 <= i_wdata & `LRC_CTRL0_WMASK;
            end
            if (i_addr == `LRC_OFF_CTRL1) begin
                ctrl1 <= i_wdata & `LRC_CTRL1_WMASK;
            end
        end
    end

    // Read data; unmapped addresses and unused bits return zero.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `LRC_OFF_CTRL0: o_rdata <= ctrl0;
                `LRC_OFF_CTRL1: o_rdata <= ctrl1;
                `LRC_OFF_STATUS: o_rdata <= {5'h0, o_ladder_on, pin_ovr};
                default:       o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Decoded fields handed to the ladder driver.
    assign ctl.conv_enable       = ctrl0[`LRC_BIT_EN];
    assign ctl.pin1_out_enable   = ctrl0[`LRC_BIT_OE1];
    assign ctl.pin2_out_enable   = ctrl0[`LRC_BIT_OE2];
    assign ctl.pos_source_select = ctrl0[`LRC_BIT_PSS];
    assign ctl.level_code        = ctrl1[`LRC_CODE_MSB:0];

    lrc_ladder_drv u_drv (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .ctl         (ctl),
        .o_tap_sel   (o_tap_sel),
        .o_src_sel   (o_upper_source),
        .o_ladder_on (o_ladder_on),
        .o_pin_ovr   (pin_ovr)
    );

    // Pin inputs pass two flip-flops before the port read logic sees them.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta <= 2'b00;
            pin_sync <= 2'b00;
        end else begin
            pin_meta <= i_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Overridden pins read zero and lose their digital functions.
    assign o_pin_rd           = pin_sync & ~pin_ovr;
    assign o_pin_drv_off      = pin_ovr;
    assign o_pin_pullup_off   = pin_ovr;
    assign o_pin_inbuf_off    = pin_ovr;
    assign o_ref_out_pin1     = pin_ovr[0];
    assign o_ref_out_pin2     = pin_ovr[1];
    assign o_lower_source_gnd = 1'b1;

    // The level feeds the comparator and ADC whenever the ladder runs.
    assign o_level_to_cmp = o_ladder_on;
    assign o_level_to_adc = o_ladder_on;
endmodule

// ===== bench/lrc_top_monitor.sv
// Checker of the ladder reference control top ports.
`timescale 1ns/100ps
module lrc_top_monitor
    import lrc_pkg::*;
(
    input wire logic       i_clk_sys,          // Clock.
    input wire logic       i_nrst,             // Reset.
    input wire logic [3:0] i_addr,             // Address.
    input wire logic [7:0] i_wdata,            // Write data.
    input wire logic       i_wr,               // Write strobe.
    input wire logic       i_rd,               // Read strobe.
    input lrc_byte_t       o_rdata,            // Read data.
    input wire logic [1:0] o_pin_rd,           // Pin read.
    input wire logic [1:0] o_pin_drv_off,      // Driver off.
    input lrc_tap_t        o_tap_sel,          // Tap select.
    input lrc_src_e        o_upper_source,     // Upper source.
    input wire logic       o_lower_source_gnd, // Ground end.
    input wire logic       o_ladder_on,        // Ladder on.
    input wire logic       o_ref_out_pin1,     // Pin 1 level.
    input wire logic       o_ref_out_pin2,     // Pin 2 level.
    input wire logic       o_level_to_cmp      // Comparator feed.
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // A write to control register 0 is taken at this edge.
    sequence s_wr0; i_wr && i_addr == 4'h0; endsequence
    // Settings reach the outputs two edges later.
    property p_en; s_wr0 |-> ##2 o_ladder_on == $past(i_wdata[7], 2); endproperty
    property p_oe1; s_wr0 |-> ##2 o_ref_out_pin1 == $past(i_wdata[5], 2); endproperty
    property p_oe2; s_wr0 |-> ##2 o_ref_out_pin2 == $past(i_wdata[4], 2); endproperty
    property p_src;
        s_wr0 |-> ##2 o_upper_source == ($past(i_wdata[2], 2) ? LRC_SRC_EXTREF : LRC_SRC_SUPPLY);
    endproperty
    property p_tap; o_tap_sel == 32'h0000_0000 || o_ladder_on && $onehot(o_tap_sel); endproperty
    property p_gnd; o_lower_source_gnd; endproperty
    property p_ovr; o_pin_drv_off == {o_ref_out_pin2, o_ref_out_pin1}; endproperty
    property p_prd; (o_pin_rd & o_pin_drv_off) == 2'h0; endproperty
    property p_zero; i_rd && i_addr == 4'h0 |=> (o_rdata & 8'h4b) == 8'h00; endproperty
    property p_zero1; i_rd && i_addr == 4'h1 |=> (o_rdata & 8'he0) == 8'h00; endproperty
    property p_cmp; o_level_to_cmp == o_ladder_on; endproperty
    a_en: assert property (p_en) else $error("enable did not follow write");
    a_oe1: assert property (p_oe1) else $error("pin 1 did not follow write");
    a_oe2: assert property (p_oe2) else $error("pin 2 did not follow write");
    a_src: assert property (p_src) else $error("source did not follow write");
    a_tap: assert property (p_tap) else $error("tap select not one-hot");
    a_gnd: assert property (p_gnd) else $error("lower end not grounded");
    a_ovr: assert property (p_ovr) else $error("override mismatch");
    a_prd: assert property (p_prd) else $error("overridden pin read high");
    a_zero: assert property (p_zero) else $error("unused bits read high");
    a_zero1: assert property (p_zero1) else $error("unused level bits read high");
    a_cmp: assert property (p_cmp) else $error("comparator feed mismatch");
endmodule

// ===== bench/lrc_top_tb_top.sv
// Self-checking bench of the ladder reference control.
`timescale 1ns/100ps
bind lrc_top lrc_top_monitor u_mon (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pin_rd,
    .o_pin_drv_off, .o_tap_sel, .o_upper_source, .o_lower_source_gnd, .o_ladder_on, .o_ref_out_pin1,
    .o_ref_out_pin2, .o_level_to_cmp);
module lrc_top_tb_top;
    import lrc_pkg::*;
    logic       i_clk_sys = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_sleep_wake = 0, rd_d = 0;
    logic [3:0] i_addr = 0;
    logic [7:0] i_wdata = 0, r, c;
    logic [1:0] i_pin_in = 0, o_pin_rd, o_pin_drv_off, o_pin_pullup_off, o_pin_inbuf_off;
    logic       o_lower_source_gnd, o_ladder_on, o_ref_out_pin1, o_ref_out_pin2, o_level_to_cmp, o_level_to_adc;
    lrc_byte_t  o_rdata;
    lrc_tap_t   o_tap_sel;
    lrc_src_e   o_upper_source;
    lrc_byte_t  exp_q[$];
    int         fail_count = 0, checked = 0, cyc = 0, seed = 97230;
    lrc_top dut_u (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep_wake, .i_pin_in,
        .o_pin_rd, .o_pin_drv_off, .o_pin_pullup_off, .o_pin_inbuf_off, .o_tap_sel, .o_upper_source,
        .o_lower_source_gnd, .o_ladder_on, .o_ref_out_pin1, .o_ref_out_pin2, .o_level_to_cmp, .o_level_to_adc);
    // Clock of 8 ns period.
    always #4 i_clk_sys = ~i_clk_sys;
    task close_out;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_rd(lrc_byte_t e, lrc_byte_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] rdata expected %h seen %h", e, g);
        end
    endtask
    task wr(logic [3:0] a, logic [7:0] d);
        @(posedge i_clk_sys); i_wr <= 1; i_rd <= 0; i_addr <= a; i_wdata <= d;
    endtask
    task rd(logic [3:0] a, logic [7:0] e);
        @(posedge i_clk_sys); i_rd <= 1; i_wr <= 0; i_addr <= a; exp_q.push_back(e);
    endtask
    task idle(int n);
        repeat (n) begin @(posedge i_clk_sys); i_wr <= 0; i_rd <= 0; end
    endtask
    task outs(logic [7:0] v, logic [4:0] k);
        #1;
        chk("on", v[7], o_ladder_on);
        chk("pins", {v[4], v[5]}, {o_ref_out_pin2, o_ref_out_pin1});
        chk("ovr", {3{v[4], v[5]}}, {o_pin_drv_off, o_pin_pullup_off, o_pin_inbuf_off});
        chk("src", v[2] ? LRC_SRC_EXTREF : LRC_SRC_SUPPLY, o_upper_source);
        chk("tap", v[7] ? 32'h0000_0001 << k : 32'h0000_0000, o_tap_sel);
        chk("pinrd", i_pin_in & ~{v[4], v[5]}, o_pin_rd);
        chk("lvl", {2{v[7]}}, {o_level_to_cmp, o_level_to_adc});
    endtask
    // Cuts a hung run short.
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin fail_count++; close_out(); end
    end
    // Read data stand in the cycle after the strobe and are compared with the oldest note.
    always @(posedge i_clk_sys) rd_d <= i_rd;
    always @(negedge i_clk_sys) if (rd_d === 1'b1) chk_rd(exp_q.pop_front(), o_rdata);
    // Main sequence: reset, every level code, wake, reset again.
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_nrst <= 1;
        rd(0, 0); rd(1, 0); idle(2); outs(0, 0);
        for (int k = 0; k < 32; k++) begin
            r = $random(seed);
            c = $random(seed);
            c[4:0] = k[4:0];
            i_pin_in <= c[7:6];
            wr(0, r); wr(1, c); wr(4'hf, r);
            rd(0, r & 8'hb4); rd(1, c & 8'h1f);
            rd(2, {5'h00, r[7], r[4], r[5]}); rd(4'hf, 8'h00); idle(3); outs(r, c[4:0]);
        end
        $display("register and output test done");
        wr(0, r & 8'h7f); idle(3); outs(r & 8'h7f, c[4:0]);
        i_sleep_wake <= 1; idle(1); i_sleep_wake <= 0; rd(0, r & 8'h34); idle(2);
        $display("wake test done");
        i_nrst <= 0; idle(2); i_nrst <= 1; rd(0, 0); rd(1, 0); idle(2); outs(0, 0);
        $display("reset test done");
        close_out();
    end
endmodule
